// ---- shared/lsts_pkg.sv ----
package lsts_pkg;

  // Width of the synchronised input bundle
  localparam int IN_W = 7;

  // Bit positions inside the synchronised bundle
  localparam int B_FWD_N = 0;
  localparam int B_REV_N = 1;
  localparam int B_NEUTRAL = 2;
  localparam int B_OVERRIDE = 3;
  localparam int B_TX = 4;
  localparam int B_RTS_N = 5;
  localparam int B_DTR_N = 6;

  // Idle pin levels: no loop current, polar, no override, line idle, RTS and DTR off
  localparam logic [IN_W-1:0] SYNC_RST = 7'h73;

  // Cycles from a pin change to the registered modulator outputs
  localparam int PIN_TO_OUT = 3;

  // Polar hold latch states, one-hot
  typedef enum logic [1:0] {
    POL_FWD = 2'h1,
    POL_REV = 2'h2
  } lsts_pol_e;

  // Values after reset
  localparam lsts_pol_e POL_RST = POL_REV;
  localparam logic DATA_RST = 1'h0;
  localparam logic RTS_RST = 1'h0;
  localparam logic DTR_RST = 1'h0;

endpackage

// ---- rtl/lsts_sync.sv ----
`timescale 1ns/10ps
module lsts_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Inputs from outside the clock domain
  output logic [WIDTH-1:0] sync_out // Inputs after two flip-flops
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Both stages reset to the idle pin levels
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- rtl/lsts_top.sv ----
// Operation
// - Neutral bit is high while either loop detector sees current.
// - Forward current sets the polar latch; it holds after current stops.
// - Reverse current flips the polar latch until direction changes again.
// - Serial select high routes serial transmit data to the modulator.
// - Serial select low and neutral switch route the neutral bit.
// - Serial select low and polar switch route the polar latch.
// - Polarity switch is ignored while serial select is high.
// - Level-converted serial transmit data is inverted before the selector.
// - Terminal asserts DTR for serial mode; asserted DTR forces serial select.
// - Pseudo-ready override forces serial select like an asserted DTR.
// - Level-converted RTS goes to the modulator inverted.
// - Level-converted DTR goes to the modulator inverted, untouched by override.
// - Selector output leaves as modulator transmit data with no gating.
// - Logic low means mark, logic high means space.
`timescale 1ns/10ps
module lsts_top (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic fwd_det_n, // Forward-current detector, low while current flows
  input wire logic rev_det_n, // Reverse-current detector, low while current flows
  input wire logic neutral_sel, // Polarity switch, high in neutral position
  input wire logic pseudo_terminal_ready_override, // Override switch, high when active
  input wire logic tx_rcv, // Serial transmit data after line receiver
  input wire logic rts_rcv_n, // RTS after line receiver, low when asserted
  input wire logic dtr_rcv_n, // DTR after line receiver, low when asserted
  output logic modulator_tx_data, // Selected data to the modulator
  output logic mod_request_to_send, // Request line to the modulator
  output logic mod_serial_mode, // Serial-mode indication to the modulator
  output logic polar_state // Polar latch, high after forward current
);
  import lsts_pkg::*;

  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] s_in;
  logic s_fwd_n;
  logic s_rev_n;
  logic s_neutral;
  logic s_ovr;
  logic s_tx;
  logic s_rts_n;
  logic s_dtr_n;
  logic neutral_bit;
  logic serial_data;
  logic serial_sel;
  lsts_pol_e pol_q;
  lsts_pol_e pol_d;
  logic polar_bit;
  logic data_q;
  logic data_d;
  logic rts_q;
  logic rts_d;
  logic dtr_q;
  logic dtr_d;
  logic polar_q;
  logic polar_d;

  // Gather every pin into one bundle for the synchroniser
  always_comb
  begin
    pins = '0;
    pins[B_FWD_N] = fwd_det_n;
    pins[B_REV_N] = rev_det_n;
    pins[B_NEUTRAL] = neutral_sel;
    pins[B_OVERRIDE] = pseudo_terminal_ready_override;
    pins[B_TX] = tx_rcv;
    pins[B_RTS_N] = rts_rcv_n;
    pins[B_DTR_N] = dtr_rcv_n;
  end

  // Switches bounce and the loop is isolated, so all pins are synchronised
  lsts_sync #(
    .WIDTH(IN_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins),
    .sync_out(s_in)
  );

  assign s_fwd_n = s_in[B_FWD_N];
  assign s_rev_n = s_in[B_REV_N];
  assign s_neutral = s_in[B_NEUTRAL];
  assign s_ovr = s_in[B_OVERRIDE];
  assign s_tx = s_in[B_TX];
  assign s_rts_n = s_in[B_RTS_N];
  assign s_dtr_n = s_in[B_DTR_N];

  // Current in either direction counts, high level is current present
  assign neutral_bit = ~(s_fwd_n & s_rev_n);

  // Receiver output is inverted once more before the selector
  assign serial_data = ~s_tx;

  // NAND of low-active DTR and low-active override position
  assign serial_sel = ~(s_dtr_n & ~s_ovr);

  // Polar hold latch; both detectors at once cannot occur, so it holds then
  always_comb
  begin
    pol_d = pol_q;
    case (pol_q)
      POL_FWD:
      begin
        if (!s_rev_n && s_fwd_n)
          pol_d = POL_REV;
      end
      POL_REV:
      begin
        if (!s_fwd_n && s_rev_n)
          pol_d = POL_FWD;
      end
      default:
      begin
        pol_d = POL_RST;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pol_q <= POL_RST;
    else
      pol_q <= pol_d;
  end

  // Selector reads the next latch state so all paths share one latency
  assign polar_bit = (pol_d == POL_FWD);

  // Data selector and modem control lines; RTS and DTR levels are inverted, low is mark
  always_comb
  begin
    if (serial_sel)
      data_d = serial_data;
    else if (s_neutral)
      data_d = neutral_bit;
    else
      data_d = polar_bit;
    rts_d = ~s_rts_n;
    dtr_d = ~s_dtr_n;
    polar_d = polar_bit;
  end

  // Output flops only retime; nothing gates the selected data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_q <= DATA_RST;
      rts_q <= RTS_RST;
      dtr_q <= DTR_RST;
      polar_q <= 1'h0;
    end
    else
    begin
      data_q <= data_d;
      rts_q <= rts_d;
      dtr_q <= dtr_d;
      polar_q <= polar_d;
    end
  end

  assign modulator_tx_data = data_q;
  assign mod_request_to_send = rts_q;
  assign mod_serial_mode = dtr_q;
  assign polar_state = polar_q;

  // Neutral selection follows the detectors of the previous cycle
  property p_neutral_route;
    @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(serial_sel) && $past(s_neutral))
      |-> (modulator_tx_data == !($past(s_fwd_n) && $past(s_rev_n)));
  endproperty
  a_neutral_route: assert property (p_neutral_route)
    else $error("neutral data not routed");

  // Forward current sets the latch
  property p_polar_set;
    @(posedge clk) disable iff (rst)
      (!s_fwd_n && s_rev_n) |=> (pol_q == POL_FWD) && polar_state;
  endproperty
  a_polar_set: assert property (p_polar_set)
    else $error("polar latch not set by forward current");

  // No current leaves the latch where it was
  property p_polar_hold;
    @(posedge clk) disable iff (rst)
      (s_fwd_n && s_rev_n) |=> $stable(pol_q);
  endproperty
  a_polar_hold: assert property (p_polar_hold)
    else $error("polar latch changed without current");

  // Reverse current flips the latch
  property p_polar_flip;
    @(posedge clk) disable iff (rst)
      (s_fwd_n && !s_rev_n) |=> (pol_q == POL_REV) && !polar_state;
  endproperty
  a_polar_flip: assert property (p_polar_flip)
    else $error("polar latch not flipped by reverse current");

  // Serial select passes inverted serial data whatever the switch says
  property p_serial_route;
    @(posedge clk) disable iff (rst)
      (!$past(rst) && $past(serial_sel)) |-> (modulator_tx_data == !$past(s_tx));
  endproperty
  a_serial_route: assert property (p_serial_route)
    else $error("serial data not routed");

  // Polar selection shows the latch
  property p_polar_route;
    @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(serial_sel) && !$past(s_neutral))
      |-> (modulator_tx_data == (pol_q == POL_FWD));
  endproperty
  a_polar_route: assert property (p_polar_route)
    else $error("polar latch not routed");

  // DTR or override pin held low/high selects serial data three cycles later
  property p_select_force;
    @(posedge clk) disable iff (rst)
      ((!dtr_rcv_n || pseudo_terminal_ready_override) [*4])
      |-> (modulator_tx_data == !$past(tx_rcv, PIN_TO_OUT));
  endproperty
  a_select_force: assert property (p_select_force)
    else $error("serial select not forced");

  // RTS reaches the modulator inverted after the fixed pin latency
  property p_rts_fwd;
    @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2) && !$past(rst, 3))
      |-> (mod_request_to_send == !$past(rts_rcv_n, 3));
  endproperty
  a_rts_fwd: assert property (p_rts_fwd)
    else $error("request line not forwarded");

  // Serial-mode line follows DTR alone, override has no say
  property p_dtr_fwd;
    @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2) && !$past(rst, 3))
      |-> (mod_serial_mode == !$past(dtr_rcv_n, 3));
  endproperty
  a_dtr_fwd: assert property (p_dtr_fwd)
    else $error("serial-mode line not forwarded");

  // Main scenarios
  property p_cov_flip;
    @(posedge clk) disable iff (rst)
      (pol_q == POL_FWD) ##1 (pol_q == POL_REV);
  endproperty
  c_cov_flip: cover property (p_cov_flip);

  property p_cov_override;
    @(posedge clk) disable iff (rst)
      s_ovr && s_dtr_n && !modulator_tx_data ##1 modulator_tx_data;
  endproperty
  c_cov_override: cover property (p_cov_override);

  property p_cov_neutral;
    @(posedge clk) disable iff (rst)
      s_neutral && !serial_sel && !s_rev_n ##1 modulator_tx_data;
  endproperty
  c_cov_neutral: cover property (p_cov_neutral);

endmodule

// ---- bench/lsts_far_end.sv ----
`timescale 1ns/10ps
module lsts_far_end (
  input wire logic [1:0] loop_cur, // Loop current: 1 forward, 2 reverse, 3 both, 0 none
  input wire logic term_ready, // Terminal on line
  input wire logic term_rts, // Terminal wants to send
  input wire logic term_space, // Terminal data, high for space
  output logic fwd_det_n, // Forward detector output
  output logic rev_det_n, // Reverse detector output
  output logic tx_rcv, // Data after line receiver
  output logic rts_rcv_n, // RTS after line receiver
  output logic dtr_rcv_n // DTR after line receiver
);
  // Isolators pull low while current flows their way; both at once is a wiring fault
  assign fwd_det_n = ~loop_cur[0];
  assign rev_det_n = ~loop_cur[1];
  // Line receiver inverts every line; serial data only counts once ready is raised or the override is on
  assign dtr_rcv_n = ~term_ready;
  assign rts_rcv_n = ~term_rts;
  assign tx_rcv = ~term_space;
endmodule

// ---- bench/tb_loop_and_serial_tx_data_selector.sv ----
`timescale 1ns/10ps
module tb_loop_and_serial_tx_data_selector;
  import lsts_pkg::*;
  typedef struct packed {logic data; logic rts; logic mode; logic pol;} lsts_exp_s;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] loop_cur = 2'h0;
  logic neutral_sel = 1'h0;
  logic ovr = 1'h0;
  logic term_ready = 1'h0;
  logic term_rts = 1'h0;
  logic term_space = 1'h0;
  logic fwd_det_n, rev_det_n, tx_rcv, rts_rcv_n, dtr_rcv_n;
  logic modulator_tx_data, mod_request_to_send, mod_serial_mode, polar_state;
  logic pol_m = 1'h0;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 89;
  logic [31:0] r;
  lsts_exp_s exp_q[$];

  lsts_far_end i_lsts_far_end (.loop_cur(loop_cur), .term_ready(term_ready), .term_rts(term_rts),
    .term_space(term_space), .fwd_det_n(fwd_det_n), .rev_det_n(rev_det_n), .tx_rcv(tx_rcv),
    .rts_rcv_n(rts_rcv_n), .dtr_rcv_n(dtr_rcv_n));
  lsts_top i_lsts_top (.clk(clk), .rst(rst), .fwd_det_n(fwd_det_n), .rev_det_n(rev_det_n),
    .neutral_sel(neutral_sel), .pseudo_terminal_ready_override(ovr), .tx_rcv(tx_rcv),
    .rts_rcv_n(rts_rcv_n), .dtr_rcv_n(dtr_rcv_n), .modulator_tx_data(modulator_tx_data),
    .mod_request_to_send(mod_request_to_send), .mod_serial_mode(mod_serial_mode), .polar_state(polar_state));

  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  task check(input string what, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One stimulus step; the note is queued once the pipeline has caught up
  task step(input logic [1:0] lc, input logic neu, input logic o, input logic rdy, input logic rts, input logic sp);
    lsts_exp_s e;
    @(negedge clk);
    loop_cur = lc;
    neutral_sel = neu;
    ovr = o;
    term_ready = rdy;
    term_rts = rts;
    term_space = sp;
    if (lc == 2'h1)
      pol_m = 1'h1;
    else if (lc == 2'h2)
      pol_m = 1'h0;
    e.data = (rdy | o) ? sp : (neu ? (lc != 2'h0) : pol_m);
    e.rts = rts;
    e.mode = rdy;
    e.pol = pol_m;
    repeat (PIN_TO_OUT) @(posedge clk);
    exp_q.push_back(e);
  endtask

  // Reset with the loop idle, so no stale current re-sets the latch after release
  task do_reset;
    @(negedge clk);
    rst = 1'h1;
    loop_cur = 2'h0;
    pol_m = 1'h0;
    repeat (2) @(posedge clk);
    exp_q.push_back('0);
    @(negedge clk);
    rst = 1'h0;
  endtask

  // Monitor compares away from the rising edge, where outputs are settled
  always @(negedge clk)
  begin
    lsts_exp_s e;
    if (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check("modulator_tx_data", modulator_tx_data, e.data);
      check("mod_request_to_send", mod_request_to_send, e.rts);
      check("mod_serial_mode", mod_serial_mode, e.mode);
      check("polar_state", polar_state, e.pol);
    end
  end

  // Hang guard, well above the roughly 950 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    do_reset();
    // Polar latch: set, hold, flip, hold, both detectors hold
    step(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h3, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    // Neutral: reverse current gives current, no current gives none
    step(2'h2, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    step(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    // Serial via ready, switch flipped under it; then override alone
    step(2'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    step(2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    step(2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    step(2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    repeat (200)
    begin
      r = $random(seed);
      step(r[1:0], r[2], r[3], r[4], r[5], r[6]);
    end
    // Reset in mid-run returns the latch to its reverse state
    do_reset();
    repeat (100)
    begin
      r = $random(seed);
      step(r[1:0], r[2], r[3], r[4], r[5], r[6]);
    end
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule
